// ==== esp_map.vh ====
// constants for the enhanced serial port
// Summary of operation
// - mode 0: data on rxd, clock on txd
// - mode 0 clock: qualifier 0 /12, 1 /4
// - mode 0 send: start next clock, shift right
// - mode 0: after 8 bits, done flag next clock
// - mode 0 receive: enable and flag clear start
// - mode 0: 8 bits received, flag, then hold
// - mode 1: start, 8 data, stop framing
// - mode 1 baud: timer overflow over 16
// - mode 1 send aligned to divider rollover
// - sample 16x, majority of states 7,8,9
// - bad start bit aborts and rearms receiver
// - mode 1 accept: flag clear, stop check
// - mode 2: 11 bit frame with ninth bit
// - mode 2: ninth bit loaded, flag at 11th rollover
// - mode 2 accept: ninth bit and address match
// - mode 2 baud: system clock /64 or /32
// - mode 3: mode 2 frame, mode 1 baud
// - timer select bits pick timer two or four
// - timer two overflow drives the mode 1 and 3 baud rate
// - timer four overflow drives the mode 1 and 3 baud rate
// - mode select bits choose four modes
`ifndef ESP_MAP_VH
`define ESP_MAP_VH

// ****************************************
// mode codes
// ****************************************
`define ESP_MODE0 2'h0
`define ESP_MODE1 2'h1
`define ESP_MODE2 2'h2
`define ESP_MODE3 2'h3

// ****************************************
// timing counts
// ****************************************
`define ESP_M0_SLOW_LAST 4'hB
`define ESP_M0_SLOW_HALF 4'h5
`define ESP_M0_FAST_LAST 4'h3
`define ESP_M0_FAST_HALF 4'h1
`define ESP_M0_BITS 4'h8
`define ESP_M2_PRE_SLOW 2'h3
`define ESP_M2_PRE_FAST 2'h1
`define ESP_SMP_A 4'h7
`define ESP_SMP_B 4'h8
`define ESP_SMP_C 4'h9
`define ESP_DIV_LAST 4'hF

// ****************************************
// frame lengths
// ****************************************
`define ESP_TX_BITS_10 4'h9
`define ESP_TX_BITS_11 4'hA
`define ESP_RX_LAST_10 4'h9
`define ESP_RX_LAST_11 4'hA

`endif

// ==== esp_div16.v ====
// divide-by-16 counter with rollover pulse
`timescale 1ns/100ps
module esp_div16 (
  input wire clk, // system clock
  input wire rst_n, // synchronous reset, active low
  input wire clr, // restart count at zero
  input wire tick, // 16x rate enable
  output reg [3:0] state_r, // current sixteenth
  output wire roll // pulse on rollover
);
`include "esp_map.vh"

  // rollover on the tick that leaves the last state
  assign roll = tick && !clr && (state_r == `ESP_DIV_LAST);

  // count ticks, clear wins
  always @(posedge clk) begin
    if (!rst_n) begin
      state_r <= 4'h0;
    end else if (clr) begin
      state_r <= 4'h0;
    end else if (tick) begin
      state_r <= state_r + 4'h1;
    end
  end
endmodule

// ==== esp_core.v ====
// serial port with one synchronous and three asynchronous modes
`timescale 1ns/100ps
module esp_core (
  input wire clk, // system clock, 40 MHz
  input wire rst_n, // synchronous reset, active low
  input wire buf_wr, // write strobe to serial buffer
  input wire [7:0] buf_wdata, // byte to send
  input wire mode_select_high, // mode bit 1
  input wire mode_select_low, // mode bit 0
  input wire mode_qualifier_bit, // rate, stop check or address gate
  input wire receive_enable, // allow reception
  input wire transmit_ninth_bit, // ninth bit to send
  input wire baud_doubling_bit, // mode 2 rate double
  input wire tx_timer_select, // 1 timer two, 0 timer four for tx
  input wire rx_timer_select, // 1 timer two, 0 timer four for rx
  input wire timer_two_ovf, // timer two overflow pulse
  input wire timer_four_ovf, // timer four overflow pulse
  input wire [7:0] given_addr, // slave address
  input wire [7:0] given_mask, // address care bits
  input wire ti_clr, // software clears transmit done
  input wire ri_clr, // software clears receive done
  input wire rxd_in, // receive data pin level
  output reg rxd_out, // receive data pin drive
  output reg rxd_oe, // receive data pin enable
  output reg txd_out, // transmit data or shift clock
  output reg [7:0] serial_buffer, // received byte
  output reg received_ninth_bit, // ninth or stop bit received
  output reg transmit_done_flag, // transmit done
  output reg receive_done_flag // receive done
);
`include "esp_map.vh"

  localparam S_IDLE = 3'h0;
  localparam S_SEND = 3'h1;
  localparam S_RECV = 3'h2;
  localparam S_TEND = 3'h3;
  localparam S_REND = 3'h4;

  // ****************************************
  // mode decode
  // ****************************************
  wire [1:0] mode = {mode_select_high, mode_select_low};
  wire is_m0 = (mode == `ESP_MODE0);
  wire is_m1 = (mode == `ESP_MODE1);
  wire is_m2 = (mode == `ESP_MODE2);
  wire nine = mode_select_high;

  // ****************************************
  // 16x rate sources
  // ****************************************
  reg [1:0] pre_r;
  wire [1:0] pre_last = baud_doubling_bit ? `ESP_M2_PRE_FAST : `ESP_M2_PRE_SLOW;
  wire pre_tick = (pre_r == pre_last);
  wire tx_tick;
  wire rx_tick;

  // fixed prescale for mode 2, 16x of /64 or /32
  always @(posedge clk) begin
    if (!rst_n || !is_m2) begin
      pre_r <= 2'h0;
    end else if (pre_tick) begin
      pre_r <= 2'h0;
    end else begin
      pre_r <= pre_r + 2'h1;
    end
  end

  // timer overflow picks per direction
  assign tx_tick = is_m2 ? pre_tick : (tx_timer_select ? timer_two_ovf : timer_four_ovf);
  assign rx_tick = is_m2 ? pre_tick : (rx_timer_select ? timer_two_ovf : timer_four_ovf);

  // ****************************************
  // mode 0 shift engine
  // ****************************************
  reg [2:0] m0_state_r;
  reg [3:0] m0_ph_r;
  reg [3:0] m0_bits_r;
  reg [7:0] m0_sr_r;
  reg m0_sclk_r;
  wire [3:0] m0_last = mode_qualifier_bit ? `ESP_M0_FAST_LAST : `ESP_M0_SLOW_LAST;
  wire [3:0] m0_half = mode_qualifier_bit ? `ESP_M0_FAST_HALF : `ESP_M0_SLOW_HALF;
  wire m0_busy = (m0_state_r == S_SEND) || (m0_state_r == S_RECV);
  wire m0_rise = m0_busy && (m0_ph_r == m0_half);
  wire m0_fall = m0_busy && (m0_ph_r == m0_last);
  wire m0_tx_set = (m0_state_r == S_TEND);
  wire m0_rx_set = (m0_state_r == S_REND);

  // mode 0 sequencer, clock generation and shifting
  always @(posedge clk) begin
    if (!rst_n || !is_m0) begin
      m0_state_r <= S_IDLE;
      m0_ph_r <= 4'h0;
      m0_bits_r <= 4'h0;
      m0_sr_r <= 8'h00;
      m0_sclk_r <= 1'b1;
    end else begin
      case (m0_state_r)
        S_IDLE: begin
          m0_ph_r <= 4'h0;
          m0_bits_r <= 4'h0;
          m0_sclk_r <= 1'b1;
          if (buf_wr) begin
            m0_state_r <= S_SEND;
            m0_sr_r <= buf_wdata;
            m0_sclk_r <= 1'b0;
          end else if (receive_enable && !receive_done_flag) begin
            m0_state_r <= S_RECV;
            m0_sclk_r <= 1'b0;
          end
        end
        S_SEND, S_RECV: begin
          m0_ph_r <= m0_fall ? 4'h0 : (m0_ph_r + 4'h1);
          if (m0_rise) begin
            m0_sclk_r <= 1'b1;
            if (m0_state_r == S_RECV) begin
              m0_sr_r <= {rxd_in, m0_sr_r[7:1]};
            end
          end
          if (m0_fall) begin
            m0_sclk_r <= 1'b0;
            m0_bits_r <= m0_bits_r + 4'h1;
            if (m0_state_r == S_SEND) begin
              m0_sr_r <= {1'b0, m0_sr_r[7:1]};
            end
            if (m0_bits_r == (`ESP_M0_BITS - 4'h1)) begin
              m0_state_r <= (m0_state_r == S_SEND) ? S_TEND : S_REND;
            end
          end
        end
        S_TEND, S_REND: begin
          m0_state_r <= S_IDLE;
          m0_sclk_r <= 1'b1;
        end
        default: begin
          m0_state_r <= S_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // asynchronous transmitter
  // ****************************************
  reg atx_pend_r;
  reg atx_busy_r;
  reg [3:0] atx_cnt_r;
  reg [9:0] atx_sr_r;
  reg atx_line_r;
  reg atx_set_r;
  wire tx_roll;

  esp_div16 u_txdiv (
    .clk(clk),
    .rst_n(rst_n),
    .clr(is_m0),
    .tick(tx_tick),
    .state_r(),
    .roll(tx_roll)
  );

  // frame sequencing on divider rollovers
  always @(posedge clk) begin
    atx_set_r <= 1'b0;
    if (!rst_n || is_m0) begin
      atx_pend_r <= 1'b0;
      atx_busy_r <= 1'b0;
      atx_cnt_r <= 4'h0;
      atx_sr_r <= 10'h3FF;
      atx_line_r <= 1'b1;
    end else begin
      if (buf_wr && !atx_busy_r) begin
        atx_pend_r <= 1'b1;
        atx_sr_r <= {1'b1, (nine ? transmit_ninth_bit : 1'b1), buf_wdata};
      end
      if (tx_roll) begin
        if (atx_pend_r && !atx_busy_r) begin
          atx_pend_r <= 1'b0;
          atx_busy_r <= 1'b1;
          atx_line_r <= 1'b0;
          atx_cnt_r <= nine ? `ESP_TX_BITS_11 : `ESP_TX_BITS_10;
        end else if (atx_busy_r) begin
          if (atx_cnt_r == 4'h0) begin
            atx_busy_r <= 1'b0;
            atx_line_r <= 1'b1;
          end else begin
            atx_line_r <= atx_sr_r[0];
            atx_sr_r <= {1'b1, atx_sr_r[9:1]};
            atx_cnt_r <= atx_cnt_r - 4'h1;
            if (atx_cnt_r == 4'h1) begin
              atx_set_r <= 1'b1;
            end
          end
        end
      end
    end
  end

  // ****************************************
  // asynchronous receiver
  // ****************************************
  reg arx_busy_r;
  reg [3:0] arx_idx_r;
  reg [8:0] arx_sr_r;
  reg arx_prev_r;
  reg arx_s0_r;
  reg arx_s1_r;
  reg arx_set_r;
  reg [7:0] arx_data_r;
  reg arx_nine_r;
  wire [3:0] rx_st;
  wire rx_fall = rx_tick && !arx_busy_r && receive_enable && arx_prev_r && !rxd_in;
  wire maj = (arx_s0_r & arx_s1_r) | (arx_s0_r & rxd_in) | (arx_s1_r & rxd_in);
  wire bit_done = arx_busy_r && rx_tick && (rx_st == `ESP_SMP_C);
  wire [3:0] rx_last = nine ? `ESP_RX_LAST_11 : `ESP_RX_LAST_10;
  wire addr_hit = (((arx_sr_r[7:0] ^ given_addr) & given_mask) == 8'h00);
  wire ok_m1 = !mode_qualifier_bit || maj;
  wire ok_m23 = !mode_qualifier_bit || (arx_sr_r[8] && addr_hit);

  esp_div16 u_rxdiv (
    .clk(clk),
    .rst_n(rst_n),
    .clr(rx_fall || is_m0),
    .tick(rx_tick),
    .state_r(rx_st),
    .roll()
  );

  // falling edge hunt, majority sampling, acceptance
  always @(posedge clk) begin
    arx_set_r <= 1'b0;
    if (!rst_n || is_m0) begin
      arx_busy_r <= 1'b0;
      arx_idx_r <= 4'h0;
      arx_sr_r <= 9'h000;
      arx_prev_r <= 1'b1;
      arx_s0_r <= 1'b1;
      arx_s1_r <= 1'b1;
      arx_data_r <= 8'h00;
      arx_nine_r <= 1'b0;
    end else begin
      if (rx_tick) begin
        arx_prev_r <= rxd_in;
      end
      if (rx_fall) begin
        arx_busy_r <= 1'b1;
        arx_idx_r <= 4'h0;
      end
      if (arx_busy_r && rx_tick && (rx_st == `ESP_SMP_A)) begin
        arx_s0_r <= rxd_in;
      end
      if (arx_busy_r && rx_tick && (rx_st == `ESP_SMP_B)) begin
        arx_s1_r <= rxd_in;
      end
      if (bit_done) begin
        arx_idx_r <= arx_idx_r + 4'h1;
        if (arx_idx_r == 4'h0) begin
          if (maj) begin
            arx_busy_r <= 1'b0;
          end
        end else if (arx_idx_r == rx_last) begin
          arx_busy_r <= 1'b0;
          if (!receive_done_flag && (nine ? ok_m23 : ok_m1)) begin
            arx_set_r <= 1'b1;
            arx_data_r <= nine ? arx_sr_r[7:0] : arx_sr_r[8:1];
            arx_nine_r <= nine ? arx_sr_r[8] : maj;
          end
        end else begin
          arx_sr_r <= {maj, arx_sr_r[8:1]};
        end
      end
    end
  end

  // ****************************************
  // buffer, flags and pins
  // ****************************************
  // receive buffer and ninth bit load
  always @(posedge clk) begin
    if (!rst_n) begin
      serial_buffer <= 8'h00;
      received_ninth_bit <= 1'b0;
    end else if (m0_rx_set) begin
      serial_buffer <= m0_sr_r;
    end else if (arx_set_r) begin
      serial_buffer <= arx_data_r;
      received_ninth_bit <= arx_nine_r;
    end
  end

  // done flags, set wins over software clear
  always @(posedge clk) begin
    if (!rst_n) begin
      transmit_done_flag <= 1'b0;
      receive_done_flag <= 1'b0;
    end else begin
      transmit_done_flag <= m0_tx_set || atx_set_r || (transmit_done_flag && !ti_clr);
      receive_done_flag <= m0_rx_set || arx_set_r || (receive_done_flag && !ri_clr);
    end
  end

  // pin drive, mode 0 owns rxd while sending
  always @(posedge clk) begin
    if (!rst_n) begin
      rxd_out <= 1'b1;
      rxd_oe <= 1'b0;
      txd_out <= 1'b1;
    end else begin
      rxd_out <= (m0_state_r == S_SEND) ? m0_sr_r[0] : 1'b1;
      rxd_oe <= is_m0 && (m0_state_r == S_SEND);
      txd_out <= is_m0 ? m0_sclk_r : atx_line_r;
    end
  end
endmodule

// ==== esp_checker.sv ====
// assertions on the serial port pins, done flags and receive buffer
`timescale 1ns/100ps
module esp_checker (
  input wire clk, // clock
  input wire rst_n, // reset
  input wire buf_wr, // write
  input wire mode_select_high, // mode hi
  input wire mode_select_low, // mode lo
  input wire receive_enable, // rx on
  input wire ti_clr, // tx clear
  input wire ri_clr, // rx clear
  input wire rxd_oe, // rxd drive
  input wire txd_out, // txd
  input wire [7:0] serial_buffer, // rx byte
  input wire transmit_done_flag, // tx done
  input wire receive_done_flag // rx done
);
  // ***
  // helpers
  // ***
  wire m0 = !mode_select_high && !mode_select_low; // sync mode
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ***
  // properties
  // ***
  a_async_no_oe: assert property ((!m0) [*3] |-> !rxd_oe)
    else $error("rxd driven in async mode");
  a_ti_sticky: assert property ($past(transmit_done_flag) && !$past(ti_clr) |-> transmit_done_flag)
    else $error("tx flag dropped");
  a_ri_sticky: assert property ($past(receive_done_flag) && !$past(ri_clr) |-> receive_done_flag)
    else $error("rx flag dropped");
  a_m0_send_start: assert property (m0 && $past(m0) && buf_wr && txd_out && !rxd_oe && !transmit_done_flag
    && !receive_enable && !$past(receive_enable) |-> ##[1:3] rxd_oe) else $error("mode 0 send late");
  a_m0_clk_idle: assert property ((m0 && !receive_enable && !rxd_oe && !buf_wr) [*6] |-> txd_out)
    else $error("shift clock outside frame");
  a_m0_rx_hold: assert property ((m0 && receive_done_flag && !rxd_oe) [*6] |-> txd_out)
    else $error("receive restarted");
  a_buf_on_flag: assert property (!$stable(serial_buffer) |-> $rose(receive_done_flag))
    else $error("buffer changed without flag");
  a_ti_at_stop: assert property ($rose(transmit_done_flag) && !m0 && !$past(m0) |-> txd_out [*8])
    else $error("tx flag not at stop bit");
  c_tx: cover property ($rose(transmit_done_flag));
  c_rx: cover property ($rose(receive_done_flag));
  c_m0: cover property ($rose(rxd_oe));
endmodule

// ==== esp_peer.sv ====
// far-side serial device model
`timescale 1ns/100ps
module esp_peer (
  input wire clk, // clock
  input wire txd, // device txd
  input wire lvl, // rxd level
  input wire oe, // device drives rxd
  input wire m0, // mode 0
  output wire rxd // our rxd drive
);
  int bt = 32; // clocks per bit
  int cnt = 8; // mode 0 bits given
  logic arx = 1'b1; // async line, idle mark
  logic [7:0] pat = 8'h00; // mode 0 byte out
  logic [7:0] got = 8'h00; // mode 0 byte in
  // after the byte, inverse of last bit
  assign rxd = !m0 ? arx : (cnt < 8) ? pat[cnt] : ~pat[7];
  // catch on rising shift clock, then advance
  always @(posedge txd) begin
    if (m0 && oe) got <= {lvl, got[7:1]};
    if (m0 && !oe && cnt < 8) cnt <= cnt + 1;
  end
  task automatic m0_load(input logic [7:0] p);
    pat = p;
    cnt = 0;
  endtask
  task automatic send(input logic [10:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      arx = f[i];
      repeat (bt) @(negedge clk);
    end
    arx = 1'b1;
  endtask
  task automatic grab(output logic [10:0] f, input int n);
    int w;
    f = 11'h000;
    w = 0;
    while (txd && w < 4000) begin
      @(negedge clk);
      w++;
    end
    repeat (bt / 2) @(negedge clk);
    for (int i = 0; i < n; i++) begin
      f[i] = txd;
      repeat (bt) @(negedge clk);
    end
  endtask
endmodule

// ==== esp_core_tb.sv ====
// self-checking bench for the serial port
`timescale 1ns/100ps
`define CHK(a, b, m) begin total_checks++; if ((a) !== (b)) begin n_errors++; $display("BAD %0t %s", $time, m); end end
module esp_core_tb;
  logic clk = 1'b0, rst_n = 1'b0, buf_wr = 1'b0, ti_clr = 1'b0, ri_clr = 1'b0, receive_enable = 1'b0;
  logic mode_select_high = 1'b0, mode_select_low = 1'b0, mode_qualifier_bit = 1'b0, transmit_ninth_bit = 1'b0;
  logic baud_doubling_bit = 1'b1, tx_timer_select = 1'b1, rx_timer_select = 1'b1;
  logic timer_two_ovf = 1'b0, timer_four_ovf = 1'b0;
  logic [7:0] buf_wdata = 8'h00, given_addr = 8'h5A, given_mask = 8'hFF;
  logic [1:0] tk = 2'h0;
  logic [10:0] fr;
  wire rxd_in, rxd_out, rxd_oe, txd_out, received_ninth_bit, transmit_done_flag, receive_done_flag, prx;
  wire [7:0] serial_buffer;
  int n_errors = 0, total_checks = 0, n;
  // clock; timer two overflows every 2 clocks, four every 4
  always #12.5 clk = ~clk;
  always @(negedge clk) begin
    tk <= tk + 2'h1;
    timer_two_ovf <= tk[0];
    timer_four_ovf <= (tk == 2'h3);
  end
  assign rxd_in = rxd_oe ? rxd_out : prx; // rxd from both drivers
  esp_core i_esp_core (.*);
  esp_peer i_esp_peer (.clk(clk), .txd(txd_out), .lvl(rxd_in), .oe(rxd_oe),
    .m0(!mode_select_high && !mode_select_low), .rxd(prx));
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] d);
    buf_wdata = d;
    buf_wr = 1'b1;
    @(negedge clk);
    buf_wr = 1'b0;
  endtask
  task automatic clr;
    ti_clr = 1'b1;
    ri_clr = 1'b1;
    @(negedge clk);
    ti_clr = 1'b0;
    ri_clr = 1'b0;
    @(negedge clk);
  endtask
  task automatic mode(input logic [1:0] m, input logic q);
    {mode_select_high, mode_select_low} = m;
    mode_qualifier_bit = q;
    repeat (4) @(negedge clk);
  endtask
  task automatic wait_flag(input logic rx);
    n = 0;
    while ((rx ? receive_done_flag : transmit_done_flag) !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic t_m0_send(input logic q);
    mode(2'h0, q);
    wr(q ? 8'h6C : 8'hA5);
    wait_flag(1'b0);
    `CHK(n, (q ? 4 : 12) * 8 + 1, "m0 length")
    `CHK(i_esp_peer.got, q ? 8'h6C : 8'hA5, "m0 send")
    clr;
  endtask
  task automatic t_m0_recv;
    mode(2'h0, 1'b1);
    i_esp_peer.m0_load(8'h3C);
    receive_enable = 1'b1;
    wait_flag(1'b1);
    repeat (60) @(negedge clk);
    `CHK(serial_buffer, 8'h3C, "m0 receive")
    `CHK({receive_done_flag, txd_out}, 2'h3, "m0 restart")
    receive_enable = 1'b0;
    clr;
  endtask
  task automatic t_tx(input logic [1:0] m, input logic b9, input logic [7:0] d);
    mode(m, 1'b0);
    transmit_ninth_bit = b9;
    wr(d);
    i_esp_peer.grab(fr, (m == 2'h1) ? 10 : 11);
    `CHK(fr, (m == 2'h1) ? {2'h1, d, 1'b0} : {1'b1, b9, d, 1'b0}, "tx frame")
    `CHK(transmit_done_flag, 1'b1, "tx done")
    clr;
  endtask
  task automatic t_rx(input logic [1:0] m, input logic q, input logic b9, input logic [7:0] d, input logic ld);
    logic f0;
    logic [7:0] b0;
    mode(m, q);
    receive_enable = 1'b1;
    f0 = receive_done_flag;
    b0 = serial_buffer;
    i_esp_peer.send((m == 2'h1) ? {2'h1, d, 1'b0} : {1'b1, b9, d, 1'b0}, (m == 2'h1) ? 10 : 11);
    repeat (4) @(negedge clk);
    `CHK(receive_done_flag, ld | f0, "rx done")
    `CHK(serial_buffer, ld ? d : b0, "rx byte")
    if (ld) `CHK(received_ninth_bit, (m == 2'h1) | b9, "rx ninth")
  endtask
  task automatic t_abort;
    mode(2'h1, 1'b0);
    receive_enable = 1'b1;
    i_esp_peer.arx = 1'b0;
    repeat (6) @(negedge clk);
    i_esp_peer.arx = 1'b1;
    repeat (64) @(negedge clk);
    `CHK(receive_done_flag, 1'b0, "glitch taken")
    // stop bit low with the stop check on must be dropped
    mode(2'h1, 1'b1);
    i_esp_peer.send(11'h0F0, 10);
    repeat (4) @(negedge clk);
    `CHK(receive_done_flag, 1'b0, "bad stop taken")
    t_rx(2'h1, 1'b0, 1'b0, 8'hA7, 1'b1);
  endtask
  // main sequence
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    `CHK({txd_out, rxd_oe, transmit_done_flag, receive_done_flag, serial_buffer}, 12'h800, "reset")
    t_m0_send(1'b0);
    t_m0_send(1'b1);
    t_m0_recv;
    t_tx(2'h1, 1'b0, 8'h96);
    t_tx(2'h2, 1'b1, 8'h3B);
    t_tx(2'h3, 1'b0, 8'hC4);
    tx_timer_select = 1'b0;
    i_esp_peer.bt = 64;
    t_tx(2'h1, 1'b1, 8'h5A);
    // slow fixed rate and timer four on the receive side, both at 64 clocks a bit
    baud_doubling_bit = 1'b0;
    t_tx(2'h2, 1'b0, 8'h69);
    baud_doubling_bit = 1'b1;
    rx_timer_select = 1'b0;
    t_rx(2'h1, 1'b0, 1'b0, 8'hE1, 1'b1);
    rx_timer_select = 1'b1;
    clr;
    i_esp_peer.bt = 32;
    t_abort;
    t_rx(2'h1, 1'b0, 1'b0, 8'h11, 1'b0);
    clr;
    t_rx(2'h2, 1'b1, 1'b0, 8'h5A, 1'b0);
    t_rx(2'h2, 1'b1, 1'b1, 8'h5B, 1'b0);
    t_rx(2'h2, 1'b1, 1'b1, 8'h5A, 1'b1);
    clr;
    t_rx(2'h3, 1'b0, 1'b0, 8'hC3, 1'b1);
    wrap_up;
  end
  // watchdog
  initial begin
    repeat (20000) @(negedge clk);
    n_errors++;
    wrap_up;
  end
endmodule
bind esp_core esp_checker i_esp_checker (.*);
